// [rtl/gpgc_top.sv]
// Purpose: Global control registers for two groups of eight ports
// Assumes: Alarm, sync and channel sources come from logic on clk_sys_in
// Notes:   All outputs registered, so pin functions other than system sync follow one cycle late
module gpgc_top
  import gpgc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rstn_in,
  // Register port
  input  wire logic [13:0] reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [7:0]  reg_rdata_out,
  // Interrupts
  input  wire logic [1:0]  irq_pending_in,
  output logic             interrupt_out_n,
  output logic             irq_out,
  // Per-port alarm sources
  input  wire logic [15:0] rx_frame_loss_in,
  input  wire logic [15:0] tx_clock_loss_in,
  input  wire logic [15:0] rx_signaling_freeze_in,
  input  wire logic [15:0] framer_signal_loss_in,
  input  wire logic [15:0] line_signal_loss_in,
  // General-purpose pins
  input  wire logic [15:0] gpio_pin_in,
  output logic      [15:0] gpio_pin_out,
  output logic      [15:0] gpio_pin_oe_n_out,
  // Shared sync and channel pins
  input  wire logic [15:0] rx_frame_sync_in,
  input  wire logic [15:0] rx_multiframe_sync_in,
  output logic      [15:0] rx_sync_pin_out,
  input  wire logic [15:0] tx_channel_block_in,
  input  wire logic [15:0] tx_channel_clock_in,
  output logic      [15:0] tx_channel_pin_out,
  input  wire logic [15:0] rx_channel_block_in,
  input  wire logic [15:0] rx_channel_clock_in,
  output logic      [15:0] rx_channel_pin_out,
  // Transmit sync pins
  input  wire logic [15:0] tx_frame_sync_in,
  input  wire logic [15:0] tx_frame_sync_oe_n_in,
  input  wire logic [15:0] tx_system_sync_in,
  output logic      [15:0] tx_sync_pin_out,
  output logic      [15:0] tx_sync_pin_oe_n_out,
  // Framer and backplane controls
  output logic             backplane_clock_out_a,
  output logic             backplane_clock_out_b,
  output logic      [1:0]  counter_latch_strobe_out,
  output logic      [1:0]  ganged_interleave_enable_out,
  output logic      [1:0]  ilv_mux_enable_out,
  output logic      [3:0]  interleave_mode_select_out
);

  logic [GROUPS-1:0][7:0]  xc_reg;
  logic [GROUPS-1:0][7:0]  fp_reg;
  logic [GROUPS-1:0][7:0]  ts_reg;
  logic [GROUPS-1:0][7:0]  gpio_s1_reg;
  logic [GROUPS-1:0][7:0]  gpio_s2_reg;
  logic [GROUPS-1:0][7:0]  gpio_s3_reg;
  logic [GROUPS-1:0][7:0]  gpio_stable_reg;
  logic [GROUPS-1:0][31:0] bp_acc_reg;
  logic [GROUPS-1:0]       bp_clk_reg;
  logic [GROUPS-1:0]       bp_rise;
  logic [GROUPS-1:0]       grp_pending;
  logic [EV_W-1:0]         ev_status_reg;
  logic [EV_W-1:0]         ev_mask_reg;
  logic [EV_W-1:0]         ev_set;
  logic [7:0]              rdata_next;
  logic                    wr_status;
  logic                    wr_mask;

  assign wr_status = reg_wr_in && (reg_addr_in == EVENT_STATUS_ADDR);
  assign wr_mask   = reg_wr_in && (reg_addr_in == EVENT_MASK_ADDR);

  genvar g;
  generate
    for (g = 0; g < GROUPS; g++) begin : gen_group
      localparam logic [13:0] XC_ADDR = (g == 0) ?
        GROUP_A_TRANSCEIVER_CONTROL_ADDR : GROUP_B_TRANSCEIVER_CONTROL_ADDR;
      localparam logic [13:0] FP_ADDR = (g == 0) ?
        GROUP_A_FRAMER_PIN_CONTROL_ADDR : GROUP_B_FRAMER_PIN_CONTROL_ADDR;
      localparam logic [13:0] TS_ADDR = (g == 0) ?
        GROUP_A_TX_SYNC_PIN_CONTROL_ADDR : GROUP_B_TX_SYNC_PIN_CONTROL_ADDR;

      logic            wr_xc;
      logic            wr_fp;
      logic            wr_ts;
      logic            latch_rise;
      gpgc_gpio_src_t  gpio_src;
      logic [1:0]      bp_sel;
      logic [1:0]      ilv_mode;
      logic [31:0]     bp_inc;
      logic [7:0]      gpio_sel_val;
      logic [7:0]      sync_now;

      // Address decode keeps each copy to its own group
      assign wr_xc = reg_wr_in && (reg_addr_in == XC_ADDR);
      assign wr_fp = reg_wr_in && (reg_addr_in == FP_ADDR);
      assign wr_ts = reg_wr_in && (reg_addr_in == TS_ADDR);

      always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
          xc_reg[g] <= REG_RESET;
          fp_reg[g] <= REG_RESET;
          ts_reg[g] <= REG_RESET;
        end else begin
          if (wr_xc) begin
            xc_reg[g] <= reg_wdata_in & XC_WMASK;
          end
          if (wr_fp) begin
            fp_reg[g] <= reg_wdata_in & FP_WMASK;
          end
          if (wr_ts) begin
            ts_reg[g] <= reg_wdata_in & TS_WMASK;
          end
        end
      end

      // Only a written 0-to-1 step fires; rewriting 1 does nothing
      assign latch_rise = wr_xc && reg_wdata_in[XC_LATCH_BIT]
                          && !xc_reg[g][XC_LATCH_BIT];

      always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
          counter_latch_strobe_out[g] <= 1'b0;
        end else begin
          counter_latch_strobe_out[g] <= latch_rise;
        end
      end

      // Interleave controls for the framers and the internal mux
      assign ilv_mode = fp_reg[g][FP_ILV_LSB +: 2];
      always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
          ganged_interleave_enable_out[g]   <= 1'b0;
          ilv_mux_enable_out[g]             <= 1'b0;
          interleave_mode_select_out[g*2 +: 2] <= ILV_DISABLED;
        end else begin
          ganged_interleave_enable_out[g] <=
            xc_reg[g][XC_GANGED_BIT];
          ilv_mux_enable_out[g] <= !xc_reg[g][XC_GANGED_BIT]
                                   && (ilv_mode != ILV_DISABLED);
          interleave_mode_select_out[g*2 +: 2] <= ilv_mode;
        end
      end

      // Phase accumulator; jitter of one system clock is the price
      assign bp_sel = fp_reg[g][FP_BPSEL_LSB +: 2];
      always_comb begin
        unique case (bp_sel)
          2'h0: bp_inc = BP_INC_2M;
          2'h1: bp_inc = BP_INC_4M;
          2'h2: bp_inc = BP_INC_8M;
          2'h3: bp_inc = BP_INC_16M;
        endcase
      end

      always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
          bp_acc_reg[g] <= 32'h0;
          bp_clk_reg[g] <= 1'b0;
        end else begin
          bp_acc_reg[g] <= bp_acc_reg[g] + bp_inc;
          bp_clk_reg[g] <= bp_acc_reg[g][31];
        end
      end
      assign bp_rise[g] = bp_acc_reg[g][31] && !bp_clk_reg[g];

      // Gpio source selection per group, one select shared by its eight ports
      assign gpio_src = gpgc_gpio_src_t'(xc_reg[g][XC_GPIO_SEL_LSB +: 3]);
      always_comb begin
        unique case (gpio_src)
          GPGC_SRC_FRAME_LOSS:  gpio_sel_val = rx_frame_loss_in[g*8 +: 8];
          GPGC_SRC_TXCLK_LOSS:  gpio_sel_val = tx_clock_loss_in[g*8 +: 8];
          GPGC_SRC_SIG_FREEZE:  gpio_sel_val = rx_signaling_freeze_in[g*8 +: 8];
          GPGC_SRC_FRAMER_LOSS: gpio_sel_val = framer_signal_loss_in[g*8 +: 8];
          GPGC_SRC_LINE_LOSS:   gpio_sel_val = line_signal_loss_in[g*8 +: 8];
          GPGC_SRC_ZERO:        gpio_sel_val = 8'h00;
          GPGC_SRC_ONE:         gpio_sel_val = 8'hff;
          GPGC_SRC_RESERVED:    gpio_sel_val = 8'h00;
        endcase
      end

      // Pin functions, one register stage for every pin output
      assign sync_now = ts_reg[g][TS_DIR_BIT] ? tx_system_sync_in[g*8 +: 8]
                                              : 8'h00;
      always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
          gpio_pin_out[g*8 +: 8]         <= 8'h00;
          gpio_pin_oe_n_out[g*8 +: 8]    <= 8'hff;
          rx_sync_pin_out[g*8 +: 8]      <= 8'h00;
          tx_channel_pin_out[g*8 +: 8]   <= 8'h00;
          rx_channel_pin_out[g*8 +: 8]   <= 8'h00;
        end else begin
          gpio_pin_out[g*8 +: 8] <= gpio_sel_val;
          gpio_pin_oe_n_out[g*8 +: 8] <=
            {8{!xc_reg[g][XC_GPIO_OE_BIT]}};
          rx_sync_pin_out[g*8 +: 8] <= fp_reg[g][FP_RX_SYNC_BIT] ?
            rx_multiframe_sync_in[g*8 +: 8] :
            rx_frame_sync_in[g*8 +: 8];
          tx_channel_pin_out[g*8 +: 8] <= fp_reg[g][FP_TX_BLK_CLK_BIT] ?
            tx_channel_clock_in[g*8 +: 8] :
            tx_channel_block_in[g*8 +: 8];
          rx_channel_pin_out[g*8 +: 8] <= fp_reg[g][FP_RX_BLK_CLK_BIT] ?
            rx_channel_clock_in[g*8 +: 8] :
            rx_channel_block_in[g*8 +: 8];
        end
      end

      // System sync output changes only on backplane clock rising edges
      always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
          tx_sync_pin_out[g*8 +: 8]      <= 8'h00;
          tx_sync_pin_oe_n_out[g*8 +: 8] <= 8'hff;
        end else if (ts_reg[g][TS_PIN_SEL_BIT]) begin
          tx_sync_pin_oe_n_out[g*8 +: 8] <=
            {8{!ts_reg[g][TS_DIR_BIT]}};
          if (bp_rise[g]) begin
            tx_sync_pin_out[g*8 +: 8] <= sync_now;
          end
        end else begin
          tx_sync_pin_out[g*8 +: 8] <= tx_frame_sync_in[g*8 +: 8];
          tx_sync_pin_oe_n_out[g*8 +: 8] <= tx_frame_sync_oe_n_in[g*8 +: 8];
        end
      end

      // Pin synchroniser; change accepted once stages two and three agree
      always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
          gpio_s1_reg[g]     <= 8'h00;
          gpio_s2_reg[g]     <= 8'h00;
          gpio_s3_reg[g]     <= 8'h00;
          gpio_stable_reg[g] <= 8'h00;
        end else begin
          gpio_s1_reg[g] <= gpio_pin_in[g*8 +: 8];
          gpio_s2_reg[g] <= gpio_s1_reg[g];
          gpio_s3_reg[g] <= gpio_s2_reg[g];
          if (gpio_s2_reg[g] == gpio_s3_reg[g]) begin
            gpio_stable_reg[g] <= gpio_s3_reg[g];
          end
        end
      end

      assign ev_set[EV_LATCH_0 + g] = latch_rise;
      assign ev_set[EV_GPIO_0 + g]  = !xc_reg[g][XC_GPIO_OE_BIT]
        && (gpio_s2_reg[g] == gpio_s3_reg[g])
        && (gpio_s3_reg[g] != gpio_stable_reg[g]);

      // Inhibit bit removes the whole group from the interrupt pin
      assign grp_pending[g] = !xc_reg[g][XC_INHIBIT_BIT] && (irq_pending_in[g]
        || |(ev_status_reg[g +: 1] & ev_mask_reg[g +: 1])
        || |(ev_status_reg[EV_GPIO_0 + g +: 1]
             & ev_mask_reg[EV_GPIO_0 + g +: 1]));

      AST_GPIO_INPUT: assert property (@(posedge clk_sys_in)
        disable iff (!rstn_in)
        !xc_reg[g][XC_GPIO_OE_BIT] |=>
          gpio_pin_oe_n_out[g*8 +: 8] == 8'hff)
        else $error("gpio pins driven while disabled");
      AST_GPIO_ZERO: assert property (@(posedge clk_sys_in)
        disable iff (!rstn_in)
        (xc_reg[g][XC_GPIO_OE_BIT] && gpio_src == GPGC_SRC_ZERO) |=>
          (gpio_pin_out[g*8 +: 8] == 8'h00
           && gpio_pin_oe_n_out[g*8 +: 8] == 8'h00))
        else $error("gpio constant zero not driven");
      AST_LATCH_EDGE: assert property (@(posedge clk_sys_in)
        disable iff (!rstn_in)
        counter_latch_strobe_out[g] == $rose(xc_reg[g][XC_LATCH_BIT]))
        else $error("latch strobe not tied to rising bit");
      AST_RX_SYNC: assert property (@(posedge clk_sys_in)
        disable iff (!rstn_in)
        fp_reg[g][FP_RX_SYNC_BIT] ##1 fp_reg[g][FP_RX_SYNC_BIT] |->
          rx_sync_pin_out[g*8 +: 8] ==
          $past(rx_multiframe_sync_in[g*8 +: 8]))
        else $error("rx sync pin not multiframe sync");
      AST_ILV_MUX: assert property (@(posedge clk_sys_in)
        disable iff (!rstn_in)
        xc_reg[g][XC_GANGED_BIT] |=> !ilv_mux_enable_out[g])
        else $error("internal mux left on in ganged mode");
      AST_TXSYNC_DIR: assert property (@(posedge clk_sys_in)
        disable iff (!rstn_in)
        (ts_reg[g][TS_PIN_SEL_BIT] && !ts_reg[g][TS_DIR_BIT]) |=>
          tx_sync_pin_oe_n_out[g*8 +: 8] == 8'hff)
        else $error("system sync driven while input");
      AST_TXSYNC_SEL: assert property (@(posedge clk_sys_in)
        disable iff (!rstn_in)
        !ts_reg[g][TS_PIN_SEL_BIT] |=>
          tx_sync_pin_out[g*8 +: 8] == $past(tx_frame_sync_in[g*8 +: 8]))
        else $error("tx sync pin not frame sync");
      COV_LATCH: cover property (@(posedge clk_sys_in)
        counter_latch_strobe_out[g] ##[1:20] counter_latch_strobe_out[g]);
    end
  endgenerate

  assign backplane_clock_out_a = bp_clk_reg[0];
  assign backplane_clock_out_b = bp_clk_reg[1];

  // Sticky events; a set in the clearing cycle wins
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ev_status_reg <= EV_RESET;
      ev_mask_reg   <= EV_RESET;
    end else begin
      ev_status_reg <= (ev_status_reg
        & ~(wr_status ? reg_wdata_in[EV_W-1:0] : EV_RESET)) | ev_set;
      if (wr_mask) begin
        ev_mask_reg <= reg_wdata_in[EV_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      interrupt_out_n <= 1'b1;
      irq_out         <= 1'b0;
    end else begin
      interrupt_out_n <= !(|grp_pending);
      irq_out         <= |(ev_status_reg & ev_mask_reg);
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    unique case (reg_addr_in)
      GROUP_A_TRANSCEIVER_CONTROL_ADDR: rdata_next = xc_reg[0];
      GROUP_A_FRAMER_PIN_CONTROL_ADDR:  rdata_next = fp_reg[0];
      GROUP_A_TX_SYNC_PIN_CONTROL_ADDR: rdata_next = ts_reg[0];
      GROUP_A_GPIO_READ_ADDR:           rdata_next = gpio_stable_reg[0];
      GROUP_B_TRANSCEIVER_CONTROL_ADDR: rdata_next = xc_reg[1];
      GROUP_B_FRAMER_PIN_CONTROL_ADDR:  rdata_next = fp_reg[1];
      GROUP_B_TX_SYNC_PIN_CONTROL_ADDR: rdata_next = ts_reg[1];
      GROUP_B_GPIO_READ_ADDR:           rdata_next = gpio_stable_reg[1];
      EVENT_STATUS_ADDR: rdata_next = {4'h0, ev_status_reg};
      EVENT_MASK_ADDR:   rdata_next = {4'h0, ev_mask_reg};
      default:           rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= 8'h00;
    end else begin
      reg_rdata_out <= reg_rd_in ? rdata_next : 8'h00;
    end
  end

  AST_INT_DRIVE: assert property (@(posedge clk_sys_in)
    disable iff (!rstn_in)
    (irq_pending_in[0] && !xc_reg[0][XC_INHIBIT_BIT]) |=> !interrupt_out_n)
    else $error("interrupt pin not driven low");
  AST_INT_INHIBIT: assert property (@(posedge clk_sys_in)
    disable iff (!rstn_in)
    (xc_reg[0][XC_INHIBIT_BIT] && xc_reg[1][XC_INHIBIT_BIT]) |=>
      interrupt_out_n)
    else $error("interrupt pin low while inhibited");
  AST_RESERVED: assert property (@(posedge clk_sys_in)
    disable iff (!rstn_in)
    (reg_rd_in && reg_addr_in == GROUP_A_TX_SYNC_PIN_CONTROL_ADDR) |=>
      reg_rdata_out[7:2] == 6'h00)
    else $error("reserved bits read nonzero");
  AST_GROUP: assert property (@(posedge clk_sys_in)
    disable iff (!rstn_in)
    (reg_wr_in && reg_addr_in == GROUP_A_TRANSCEIVER_CONTROL_ADDR) |=>
      $stable(xc_reg[1]))
    else $error("group A write changed group B");
  COV_INHIBIT: cover property (@(posedge clk_sys_in)
    irq_pending_in[0] && xc_reg[0][XC_INHIBIT_BIT] ##1 interrupt_out_n);
  COV_GPIO_OUT: cover property (@(posedge clk_sys_in)
    gpio_pin_oe_n_out[0] == 1'b0);
endmodule // gpgc_top

// [rtl/gpgc_pkg.sv]
// Purpose: Constants for the global port group control register bank
// Assumes: 100 MHz system clock, 8-bit register port, two port groups
// Notes:   Addresses are byte offsets on the register port
package gpgc_pkg;
  localparam int GROUPS   = 2;
  localparam int PORTS    = 8;
  localparam int ADDR_W   = 14;
  localparam int DATA_W   = 8;

  // Register addresses
  localparam logic [13:0] GROUP_A_TRANSCEIVER_CONTROL_ADDR = 14'h00f0;
  localparam logic [13:0] GROUP_A_FRAMER_PIN_CONTROL_ADDR  = 14'h00f1;
  localparam logic [13:0] GROUP_A_TX_SYNC_PIN_CONTROL_ADDR = 14'h00f2;
  localparam logic [13:0] GROUP_A_GPIO_READ_ADDR           = 14'h00ff;
  localparam logic [13:0] GROUP_B_TRANSCEIVER_CONTROL_ADDR = 14'h20f0;
  localparam logic [13:0] GROUP_B_FRAMER_PIN_CONTROL_ADDR  = 14'h20f1;
  localparam logic [13:0] GROUP_B_TX_SYNC_PIN_CONTROL_ADDR = 14'h20f2;
  localparam logic [13:0] GROUP_B_GPIO_READ_ADDR           = 14'h20ff;
  localparam logic [13:0] EVENT_STATUS_ADDR                = 14'h30f0;
  localparam logic [13:0] EVENT_MASK_ADDR                  = 14'h30f1;

  // Transceiver control fields
  localparam int XC_INHIBIT_BIT  = 0;
  localparam int XC_LATCH_BIT    = 1;
  localparam int XC_GANGED_BIT   = 2;
  localparam int XC_GPIO_OE_BIT  = 4;
  localparam int XC_GPIO_SEL_LSB = 5;
  // Framer pin control fields
  localparam int FP_RX_BLK_CLK_BIT = 0;
  localparam int FP_TX_BLK_CLK_BIT = 1;
  localparam int FP_RX_SYNC_BIT    = 2;
  localparam int FP_BPSEL_LSB      = 4;
  localparam int FP_ILV_LSB        = 6;
  // Transmit sync pin control fields
  localparam int TS_PIN_SEL_BIT = 0;
  localparam int TS_DIR_BIT     = 1;

  // Writable bits; the rest are reserved and read zero
  localparam logic [7:0] XC_WMASK  = 8'hf7;
  localparam logic [7:0] FP_WMASK  = 8'hf7;
  localparam logic [7:0] TS_WMASK  = 8'h03;
  localparam logic [7:0] REG_RESET = 8'h00;

  // Event status bits
  localparam int EV_W       = 4;
  localparam int EV_LATCH_0 = 0;
  localparam int EV_GPIO_0  = 2;
  localparam logic [3:0] EV_RESET = 4'h0;

  typedef enum logic [2:0] {
    GPGC_SRC_FRAME_LOSS  = 3'h0,
    GPGC_SRC_TXCLK_LOSS  = 3'h1,
    GPGC_SRC_SIG_FREEZE  = 3'h2,
    GPGC_SRC_FRAMER_LOSS = 3'h3,
    GPGC_SRC_LINE_LOSS   = 3'h4,
    GPGC_SRC_ZERO        = 3'h5,
    GPGC_SRC_ONE         = 3'h6,
    GPGC_SRC_RESERVED    = 3'h7
  } gpgc_gpio_src_t;

  localparam logic [1:0] ILV_DISABLED = 2'h0;

  // Backplane clock synthesis by phase accumulator
  localparam longint CLK_HZ    = 100_000_000;
  localparam longint BP_2M_HZ  = 2_048_000;
  localparam longint BP_4M_HZ  = 4_096_000;
  localparam longint BP_8M_HZ  = 8_192_000;
  localparam longint BP_16M_HZ = 16_384_000;
  localparam logic [31:0] BP_INC_2M  = 32'((BP_2M_HZ << 32) / CLK_HZ);
  localparam logic [31:0] BP_INC_4M  = 32'((BP_4M_HZ << 32) / CLK_HZ);
  localparam logic [31:0] BP_INC_8M  = 32'((BP_8M_HZ << 32) / CLK_HZ);
  localparam logic [31:0] BP_INC_16M = 32'((BP_16M_HZ << 32) / CLK_HZ);
endpackage : gpgc_pkg

// [testbench/gpgc_far_model.sv]
// Purpose: Far-side source model for the port group control bench
// Assumes: Framer and backplane sources hold steady levels
// Notes:   Halves differ so a group mix-up shows at once
module gpgc_far_model (
  // Per-port sources
  output logic [15:0] src_out [14]
);
  timeunit 1ns;
  timeprecision 100ps;
  for (genvar k = 0; k < 14; k++) begin : g_src
    assign src_out[k] = 16'ha5c3 ^ {2{8'(k)}};
  end
endmodule // gpgc_far_model

// [testbench/global_port_group_control_bench.sv]
// Purpose: Self-checking bench for the port group control registers
// Assumes: Far model sources follow the pattern mirrored in p
// Notes:   Pins are sampled two cycles after the controlling write; system sync waits sixty, backplane clocks four
module global_port_group_control_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import gpgc_pkg::*;
  logic clk_sys_in = 0, rstn_in = 0, reg_wr_in = 0, reg_rd_in = 0;
  logic [13:0] reg_addr_in = 0;
  logic [7:0]  reg_wdata_in = 0, reg_rdata_out, d;
  logic [1:0]  irq_pending_in = 0, counter_latch_strobe_out;
  logic [1:0]  ganged_interleave_enable_out, ilv_mux_enable_out;
  logic [3:0]  interleave_mode_select_out;
  logic [15:0] gpio_pin_in = 0, gpio_pin_out, gpio_pin_oe_n_out;
  logic [15:0] rx_sync_pin_out, tx_channel_pin_out, rx_channel_pin_out;
  logic [15:0] tx_sync_pin_out, tx_sync_pin_oe_n_out, p [14], src [14];
  logic interrupt_out_n, irq_out, backplane_clock_out_a;
  logic backplane_clock_out_b, pb, pbb;
  int n_errors = 0, checked = 0, k, cnt, cnt_b, lo;
  localparam logic [13:0] ADR [6] = '{14'h00f0, 14'h00f1, 14'h00f2,
    14'h20f0, 14'h20f1, 14'h20f2};
  localparam logic [7:0] MSK [6] = '{8'hf7, 8'hf7, 8'h03,
    8'hf7, 8'hf7, 8'h03};
  always #5 clk_sys_in = ~clk_sys_in;
  gpgc_far_model far (.src_out(src));
  gpgc_top DUT (.clk_sys_in, .rstn_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .irq_pending_in,
    .interrupt_out_n, .irq_out, .rx_frame_loss_in(src[0]),
    .tx_clock_loss_in(src[1]), .rx_signaling_freeze_in(src[2]),
    .framer_signal_loss_in(src[3]), .line_signal_loss_in(src[4]),
    .gpio_pin_in, .gpio_pin_out, .gpio_pin_oe_n_out,
    .rx_frame_sync_in(src[5]), .rx_multiframe_sync_in(src[6]),
    .rx_sync_pin_out, .tx_channel_block_in(src[7]),
    .tx_channel_clock_in(src[8]), .tx_channel_pin_out,
    .rx_channel_block_in(src[9]), .rx_channel_clock_in(src[10]),
    .rx_channel_pin_out, .tx_frame_sync_in(src[11]),
    .tx_frame_sync_oe_n_in(src[12]), .tx_system_sync_in(src[13]),
    .tx_sync_pin_out, .tx_sync_pin_oe_n_out, .backplane_clock_out_a,
    .backplane_clock_out_b, .counter_latch_strobe_out,
    .ganged_interleave_enable_out, .ilv_mux_enable_out,
    .interleave_mode_select_out);
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [13:0] a, logic [7:0] v);
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= v;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rc(logic [13:0] a, logic [7:0] exp);
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1 chk("rdata", 16'(reg_rdata_out), 16'(exp));
  endtask
  task automatic wt(int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  // Counts strobe pulses in the three cycles after a control write
  task automatic lat(logic [7:0] v, int exp);
    wr(14'h00f0, v);
    cnt = 0;
    repeat (3) begin
      #1 if (counter_latch_strobe_out === 2'b01) cnt++;
      else if (counter_latch_strobe_out !== 2'b00) cnt += 10;
      @(posedge clk_sys_in);
    end
    chk("latch_pulses", 16'(cnt), 16'(exp));
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Bounds the whole run so a stuck design still reaches the verdict
  initial begin
    #900000;
    n_errors++;
    end_of_test;
  end
  initial begin
    for (k = 0; k < 14; k++) p[k] = 16'ha5c3 ^ {2{8'(k)}};
    repeat (4) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    for (k = 0; k < 6; k++) rc(ADR[k], 8'h00);
    wr(14'h1234, 8'h5a);
    rc(14'h1234, 8'h00);
    for (k = 0; k < 6; k++) begin
      wr(ADR[k], 8'hff);
      rc(ADR[k], MSK[k]);
      wr(ADR[k], 8'h00);
    end
    $display("test registers done");
    for (k = 0; k < 8; k++) begin
      wr(14'h00f0, 8'(k << 5) | 8'h10);
      wt(2);
      chk("gpio_out", 16'(gpio_pin_out[7:0]), (k < 5) ?
        16'(p[k][7:0]) : 16'({8{k == 6}}));
      chk("gpio_oe_n", gpio_pin_oe_n_out, 16'hff00);
    end
    wr(14'h00f0, 8'h00);
    wt(2);
    chk("gpio_oe_n", gpio_pin_oe_n_out, 16'hffff);
    for (k = 0; k < 2; k++) begin
      wr(14'h00f1, (k != 0) ? 8'h07 : 8'h00);
      wt(2);
      chk("rx_sync", rx_sync_pin_out, {p[5][15:8], p[5+k][7:0]});
      chk("tx_chan", tx_channel_pin_out, {p[7][15:8], p[7+k][7:0]});
      chk("rx_chan", rx_channel_pin_out, {p[9][15:8], p[9+k][7:0]});
    end
    for (k = 0; k < 4; k++) begin
      wr(14'h20f1, 8'(k << 6));
      wt(2);
      chk("ilv_mode", 16'(interleave_mode_select_out), 16'(k << 2));
      chk("ilv_mux", 16'(ilv_mux_enable_out),
        (k != 0) ? 16'h0002 : 16'h0000);
    end
    wr(14'h20f0, 8'h04);
    wr(14'h20f1, 8'hc0);
    wt(2);
    chk("ganged", 16'({ganged_interleave_enable_out, ilv_mux_enable_out}),
      16'h0008);
    $display("test pin functions done");
    wr(14'h30f0, 8'h0f);
    lat(8'h02, 1);
    lat(8'h02, 0);
    lat(8'h00, 0);
    lat(8'h02, 1);
    rc(14'h30f0, 8'h01);
    chk("irq", 16'(irq_out), 16'h0000);
    wr(14'h30f1, 8'h01);
    wt(2);
    chk("irq", 16'(irq_out), 16'h0001);
    wr(14'h30f0, 8'h01);
    wt(2);
    chk("irq", 16'(irq_out), 16'h0000);
    rc(14'h30f0, 8'h00);
    @(posedge clk_sys_in) irq_pending_in <= 2'b01;
    wt(2);
    chk("int_n", 16'(interrupt_out_n), 16'h0000);
    wr(14'h00f0, 8'h01);
    wt(2);
    chk("int_n", 16'(interrupt_out_n), 16'h0001);
    @(posedge clk_sys_in) irq_pending_in <= 2'b10;
    wt(2);
    chk("int_n", 16'(interrupt_out_n), 16'h0000);
    wr(14'h20f0, 8'h05);
    wt(2);
    chk("int_n", 16'(interrupt_out_n), 16'h0001);
    @(posedge clk_sys_in) irq_pending_in <= 2'b00;
    $display("test latch and interrupts done");
    for (k = 0; k < 4; k++) begin
      wr(14'h00f1, 8'(k << 4));
      wt(4);
      cnt = 0;
      cnt_b = 0;
      repeat (1000) begin
        pb = backplane_clock_out_a;
        pbb = backplane_clock_out_b;
        wt(1);
        if (!pb && backplane_clock_out_a) cnt++;
        if (!pbb && backplane_clock_out_b) cnt_b++;
      end
      lo = (2048 << k) / 100;
      chk("bp_edges", 16'(cnt >= lo && cnt <= lo + 1), 16'h0001);
      // Group B stays at its own 2.048 MHz setting
      chk("bp_edges_b", 16'(cnt_b >= 20 && cnt_b <= 21), 16'h0001);
    end
    wr(14'h00f1, 8'h00);
    wt(2);
    chk("tx_sync", tx_sync_pin_out, p[11]);
    chk("tx_sync_oe_n", tx_sync_pin_oe_n_out, p[12]);
    wr(14'h00f2, 8'h03);
    wt(60);
    chk("tx_sync", tx_sync_pin_out, {p[11][15:8], p[13][7:0]});
    chk("tx_sync_oe_n", tx_sync_pin_oe_n_out, {p[12][15:8], 8'h00});
    wr(14'h00f2, 8'h01);
    wt(2);
    chk("tx_sync_oe_n", tx_sync_pin_oe_n_out, {p[12][15:8], 8'hff});
    @(posedge clk_sys_in) gpio_pin_in <= 16'h3c5a;
    wt(8);
    rc(14'h00ff, 8'h5a);
    rc(14'h20ff, 8'h3c);
    @(posedge clk_sys_in) rstn_in <= 1'b0;
    wt(2);
    @(posedge clk_sys_in) rstn_in <= 1'b1;
    rc(14'h20f0, 8'h00);
    chk("ganged", 16'(ganged_interleave_enable_out), 16'h0000);
    $display("test backplane, sync and reset done");
    end_of_test;
  end
endmodule // global_port_group_control_bench
